/* dmaba_cpu_model.sv */
// Purpose: processor side of the system bus, answering hold with grant
// Assumes: hold line level is already resolved with its pull-up
// Notes: grant delay set by the bench, so the cpu can be prompt or slow
`timescale 1ns/1ns
`default_nettype none
module dmaba_cpu_model (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic phold_n_in,
    input wire logic [2:0] dly_in,
    output logic phlda_out
);
    logic [2:0] wait_ff;
    // grant only once the hold line was low for dly_in edges
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wait_ff <= 3'h0;
            phlda_out <= 1'b0;
        end else if (phold_n_in) begin
            // released hold: cpu takes the bus back at its next cycle
            wait_ff <= 3'h0;
            phlda_out <= 1'b0;
        end else if (wait_ff >= dly_in) begin
            phlda_out <= 1'b1;
        end else begin
            wait_ff <= wait_ff + 3'h1;
        end
    end
endmodule : dmaba_cpu_model
`default_nettype wire

/* dmaba_pkg.sv */
// Purpose: shared constants and carriers for the dma bus acquisition block
// Assumes: 32-bit avalon-mm register port, one clock at 20 MHz
// Notes: byte addresses are word aligned
package dmaba_pkg;
    localparam int CLK_MHZ = 20;
    // register byte offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_EPCOUNT = 4'h8;
    // control register fields
    localparam int CTRL_CMD_BIT = 0;
    localparam int CTRL_DIR_BIT = 1;
    localparam int CTRL_START_BIT = 2;
    localparam int CTRL_STOP_BIT = 3;
    // status register fields
    localparam int ST_PWR_BIT = 0;
    localparam int ST_WREN_BIT = 1;
    localparam int ST_IDLE_BIT = 2;
    localparam int ST_HOLD_BIT = 3;
    localparam int ST_TAKE_BIT = 4;
    localparam int ST_WANT_BIT = 5;
    localparam int ST_GRANT_BIT = 6;
    localparam int ST_SYNCD_BIT = 7;
    // reset values
    localparam logic RST_POWER_ON_ENABLE_FLAG = 1'b0;
    localparam logic RST_IDLE = 1'b1;
    localparam logic RST_WAITREQ = 1'b1;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;
    // typical episode shape, for reference by software
    localparam int EPISODE_US = 20;
    localparam int EPISODE_BYTES = 12;
    localparam int EPISODE_GAP_US = 370;
    localparam int EPISODE_CYCLES = EPISODE_US * CLK_MHZ;
    localparam int GAP_CYCLES = EPISODE_GAP_US * CLK_MHZ;
    localparam int EPCNT_W = 8;

    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [31:0] writedata;
    } dmaba_avm_req_t;

    typedef struct packed {
        logic phold_n;
        logic phlda;
    } dmaba_bus_in_t;
endpackage : dmaba_pkg

/* dmaba_top.sv */
// Purpose: dma bus acquisition front end: request sync, hold, takeover, psync
// Assumes: mclk_in is bus clock phase two; nrst_in is the power-on clear
// Notes: phase-two trailing-edge stages are modelled on the rising edge
//
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module dmaba_top (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire dmaba_pkg::dmaba_avm_req_t avm_req_in,
    output logic avm_waitrequest_out,
    output logic [31:0] avm_readdata_out,
    input wire dmaba_pkg::dmaba_bus_in_t bus_in,
    input wire logic formatter_request_pulse_n_in,
    input wire logic episode_end_in,
    input wire logic byte_done_in,
    input wire logic transfer_done_in,
    output logic phold_out,
    output logic phold_oe_out,
    output logic psync_out,
    output logic psync_oe_out,
    output logic bus_takeover_out,
    output logic cpu_drivers_release_out,
    output logic hold_to_formatter_out,
    output logic priority_out,
    output logic io_strobe_enable_out,
    output logic disk_write_enable_out,
    output logic transfer_idle_out
);
    import dmaba_pkg::*;

    logic waitreq_ff;
    logic [31:0] rdata_ff;
    logic power_on_enable_ff;
    logic write_enable_ff;
    logic transfer_idle_ff;
    logic bus_want_ff;
    logic request_synced_ff;
    logic grant_sampled_ff;
    logic hold_ff;
    logic bus_takeover_ff;
    logic sync_done_ff;
    logic sync_pulse_ff;
    logic end_latch_ff;
    logic priority_ff;
    logic io_en_ff;
    logic [EPCNT_W-1:0] ep_bytes_ff;
    logic [EPCNT_W-1:0] last_ep_bytes_ff;
    logic hold_d_ff;

    logic bus_free;
    logic acc;
    logic wr_take;
    logic cmd_strobe;
    logic start_cmd;
    logic stop_cmd;
    logic nxt_hold;
    logic [31:0] nxt_rdata;

    // one wait state: request seen with waitrequest high, answered next cycle
    assign acc = avm_req_in.read | avm_req_in.write;
    assign wr_take = avm_req_in.write & ~waitreq_ff;
    assign cmd_strobe = wr_take & (avm_req_in.address == OFS_CTRL)
        & avm_req_in.writedata[CTRL_CMD_BIT];
    assign start_cmd = cmd_strobe & avm_req_in.writedata[CTRL_START_BIT];
    assign stop_cmd = cmd_strobe & avm_req_in.writedata[CTRL_STOP_BIT];

    // bus free: nobody holds the grant and nobody pulls the hold line
    assign bus_free = ~grant_sampled_ff & bus_in.phold_n;

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            waitreq_ff <= RST_WAITREQ;
        end else begin
            waitreq_ff <= ~(acc & waitreq_ff);
        end
    end

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        unique case (avm_req_in.address)
            OFS_STATUS: begin
                nxt_rdata[ST_PWR_BIT] = power_on_enable_ff;
                nxt_rdata[ST_WREN_BIT] = write_enable_ff;
                nxt_rdata[ST_IDLE_BIT] = transfer_idle_ff;
                nxt_rdata[ST_HOLD_BIT] = hold_ff;
                nxt_rdata[ST_TAKE_BIT] = bus_takeover_ff;
                nxt_rdata[ST_WANT_BIT] = bus_want_ff;
                nxt_rdata[ST_GRANT_BIT] = grant_sampled_ff;
                nxt_rdata[ST_SYNCD_BIT] = sync_done_ff;
            end
            OFS_EPCOUNT: begin
                nxt_rdata[EPCNT_W-1:0] = last_ep_bytes_ff;
            end
            default: begin
                nxt_rdata = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_ff <= RST_RDATA;
        end else if (avm_req_in.read & waitreq_ff) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // power enable: only the command strobe re-arms after power-on clear
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            power_on_enable_ff <= RST_POWER_ON_ENABLE_FLAG;
        end else if (cmd_strobe) begin
            power_on_enable_ff <= 1'b1;
        end
    end

    // transfer state; disabled power enable forces idle and overrides everything except a start command
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            transfer_idle_ff <= RST_IDLE;
            write_enable_ff <= 1'b0;
        end else if (!power_on_enable_ff) begin
            transfer_idle_ff <= 1'b1;
            write_enable_ff <= 1'b0;
            if (start_cmd) begin
                transfer_idle_ff <= 1'b0;
                write_enable_ff <= avm_req_in.writedata[CTRL_DIR_BIT];
            end
        end else if (stop_cmd | transfer_done_in) begin
            transfer_idle_ff <= 1'b1;
            write_enable_ff <= 1'b0;
        end else if (start_cmd) begin
            transfer_idle_ff <= 1'b0;
            write_enable_ff <= avm_req_in.writedata[CTRL_DIR_BIT];
        end
    end

    // bus-want latch: set by formatter pulse, cleared by end of episode
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bus_want_ff <= 1'b0;
        end else if (!power_on_enable_ff | transfer_idle_ff) begin
            bus_want_ff <= 1'b0;
        end else if (!formatter_request_pulse_n_in) begin
            bus_want_ff <= 1'b1;
        end else if (end_latch_ff) begin
            bus_want_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            request_synced_ff <= 1'b0;
            grant_sampled_ff <= 1'b0;
        end else begin
            request_synced_ff <= bus_want_ff;
            grant_sampled_ff <= bus_in.phlda;
        end
    end

    // jk hold: j = bus free and synced request, k = synced request low
    always_comb begin
        nxt_hold = hold_ff;
        if (bus_free & request_synced_ff) begin
            nxt_hold = 1'b1;
        end else if (!request_synced_ff) begin
            nxt_hold = 1'b0;
        end
    end

    // no priority input: once held, a foreign hold never drops ours
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hold_ff <= 1'b0;
        end else begin
            hold_ff <= nxt_hold;
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bus_takeover_ff <= 1'b0;
        end else begin
            bus_takeover_ff <= hold_ff & grant_sampled_ff;
        end
    end

    // sync pulse lasts one period and ends itself; sync-done, set by it, holds until byte done or until takeover drops
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync_pulse_ff <= 1'b0;
        end else begin
            sync_pulse_ff <= bus_takeover_ff & ~sync_done_ff & bus_want_ff
                & ~sync_pulse_ff;
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync_done_ff <= 1'b0;
        end else if (!bus_takeover_ff) begin
            sync_done_ff <= 1'b0;
        end else if (sync_pulse_ff) begin
            sync_done_ff <= 1'b1;
        end else if (byte_done_in) begin
            sync_done_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            end_latch_ff <= 1'b0;
        end else if (!hold_ff) begin
            end_latch_ff <= 1'b0;
        end else if (episode_end_in) begin
            end_latch_ff <= 1'b1;
        end
    end

    // bytes per episode, latched when the episode closes
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ep_bytes_ff <= '0;
            last_ep_bytes_ff <= '0;
            hold_d_ff <= 1'b0;
        end else begin
            hold_d_ff <= hold_ff;
            if (hold_d_ff & ~hold_ff) begin
                last_ep_bytes_ff <= ep_bytes_ff;
                ep_bytes_ff <= '0;
            end else if (sync_pulse_ff & ~(&ep_bytes_ff)) begin
                ep_bytes_ff <= ep_bytes_ff + 1'b1;
            end
        end
    end

    // registered look-ahead copies keep every output except the tied-low phold_out straight from a flop
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            priority_ff <= 1'b0;
            io_en_ff <= 1'b1;
        end else begin
            priority_ff <= ~bus_in.phlda & bus_in.phold_n & ~bus_want_ff;
            io_en_ff <= ~bus_in.phlda;
        end
    end

    assign avm_waitrequest_out = waitreq_ff;
    assign avm_readdata_out = rdata_ff;
    assign phold_out = 1'b0;
    assign phold_oe_out = hold_ff;
    assign psync_out = sync_pulse_ff;
    assign psync_oe_out = bus_takeover_ff;
    assign bus_takeover_out = bus_takeover_ff;
    assign cpu_drivers_release_out = bus_takeover_ff;
    assign hold_to_formatter_out = hold_ff;
    assign priority_out = priority_ff;
    assign io_strobe_enable_out = io_en_ff;
    assign disk_write_enable_out = write_enable_ff;
    assign transfer_idle_out = transfer_idle_ff;

    sequence s_sync_start;
        bus_takeover_ff && !sync_done_ff && bus_want_ff && !sync_pulse_ff;
    endsequence

    sequence s_sync_one;
        sync_pulse_ff ##1 (!sync_pulse_ff && sync_done_ff);
    endsequence

    a_power_clear_hold: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !power_on_enable_ff && !cmd_strobe |=> !power_on_enable_ff)
        else $error("power enable rose without command strobe");
    a_idle_forced: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !power_on_enable_ff && !start_cmd |=> transfer_idle_ff && !write_enable_ff)
        else $error("transfer active while power enable cleared");
    a_write_gated: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        disk_write_enable_out |-> !transfer_idle_ff)
        else $error("disk write enabled while transfer idle");
    a_sync_sampled: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        ##1 request_synced_ff == $past(bus_want_ff))
        else $error("synced request does not follow bus-want latch");
    a_grant_sampled: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        $rose(bus_in.phlda) |=> grant_sampled_ff)
        else $error("grant not sampled");
    a_hold_sets: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        request_synced_ff && bus_free |=> hold_ff && !phold_oe_out == 1'b0)
        else $error("hold flag did not set on free bus");
    a_hold_blocked: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !hold_ff && !bus_free |=> !hold_ff)
        else $error("hold flag set while bus busy");
    a_takeover_and: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        hold_ff && grant_sampled_ff |=> bus_takeover_out && psync_oe_out)
        else $error("takeover did not follow hold and grant");
    a_syncdone_reset: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !bus_takeover_ff |=> !sync_done_ff && !psync_out)
        else $error("sync-done active without takeover");
    a_sync_pulse_one: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        s_sync_start |=> s_sync_one)
        else $error("sync pulse not exactly one period");
    a_end_latch_rst: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !hold_ff |=> !end_latch_ff)
        else $error("end latch active without hold");

    // steps of a byte resync and of an episode close
    sequence s_byte_clear;
        bus_takeover_ff && sync_done_ff && !sync_pulse_ff && byte_done_in;
    endsequence

    sequence s_ep_close;
        hold_d_ff && !hold_ff;
    endsequence

    a_power_stays: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        power_on_enable_ff |=> power_on_enable_ff)
        else $error("power enable dropped without power-on clear");
    a_want_set: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        power_on_enable_ff && !transfer_idle_ff && !formatter_request_pulse_n_in
        |=> bus_want_ff)
        else $error("formatter request did not set bus-want");
    a_want_holds: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        bus_want_ff && power_on_enable_ff && !transfer_idle_ff && !end_latch_ff |=> bus_want_ff)
        else $error("bus-want dropped without end of episode");
    a_want_clears: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        bus_want_ff && end_latch_ff && formatter_request_pulse_n_in |=> !bus_want_ff)
        else $error("bus-want kept after end of episode");
    a_grant_follow: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        ##1 grant_sampled_ff == $past(bus_in.phlda))
        else $error("sampled grant does not follow grant line");
    a_io_gate: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        io_strobe_enable_out != grant_sampled_ff)
        else $error("port strobes enabled while grant sampled high");
    a_prio_out: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        priority_out |-> !grant_sampled_ff && !request_synced_ff)
        else $error("priority out high while bus owned or wanted");
    a_hold_keeps: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        hold_ff && request_synced_ff |=> hold_ff)
        else $error("hold flag dropped while request still synced");
    a_hold_drops: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        hold_ff && !request_synced_ff |=> !hold_ff)
        else $error("hold flag kept after request dropped");
    a_takeover_drop: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !(hold_ff && grant_sampled_ff) |=> !bus_takeover_out)
        else $error("takeover without hold and grant");
    a_byte_resync: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        s_byte_clear ##1 (bus_takeover_ff && bus_want_ff) |=> psync_out)
        else $error("no sync pulse after byte done");
    a_count_byte: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        sync_pulse_ff && (hold_ff || !hold_d_ff) && !(&ep_bytes_ff)
        |=> ep_bytes_ff == $past(ep_bytes_ff) + 8'h01)
        else $error("episode byte count did not advance");
    a_count_latch: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        s_ep_close |=> last_ep_bytes_ff == $past(ep_bytes_ff) && ep_bytes_ff == 8'h00)
        else $error("episode byte count not latched at close");
endmodule : dmaba_top
`default_nettype wire

/* test_dma_bus_acquisition.sv */
// Purpose: self-checking bench for the dma bus acquisition block
// Assumes: outputs are judged by their value sampled at the rising edge
// Notes: other_n stands for a second dma master on the open-drain hold line
`timescale 1ns/1ns
`default_nettype none
module test_dma_bus_acquisition;
    import dmaba_pkg::*;
    logic mclk_in, nrst_in, req_n, ep_end, byte_done, xfer_done, other_n, phlda;
    logic [2:0] dly;
    dmaba_avm_req_t req;
    dmaba_bus_in_t bus_s;
    logic waitreq, phold_d, phold_oe, psync, psync_oe, take, rel, hold_f, prio, io_en, wren, idle;
    logic [31:0] rdata;
    wire logic hold_line_n;
    int errors = 0;
    int checks_done = 0;
    // open drain with pull-up: low if any master pulls it
    assign hold_line_n = !(phold_oe && !phold_d) && other_n;
    assign bus_s = {hold_line_n, phlda};
    dmaba_top uut (.mclk_in(mclk_in), .nrst_in(nrst_in), .avm_req_in(req),
        .avm_waitrequest_out(waitreq), .avm_readdata_out(rdata), .bus_in(bus_s),
        .formatter_request_pulse_n_in(req_n), .episode_end_in(ep_end),
        .byte_done_in(byte_done), .transfer_done_in(xfer_done), .phold_out(phold_d),
        .phold_oe_out(phold_oe), .psync_out(psync), .psync_oe_out(psync_oe),
        .bus_takeover_out(take), .cpu_drivers_release_out(rel),
        .hold_to_formatter_out(hold_f), .priority_out(prio), .io_strobe_enable_out(io_en),
        .disk_write_enable_out(wren), .transfer_idle_out(idle));
    dmaba_cpu_model cpu (.mclk_in(mclk_in), .nrst_in(nrst_in), .phold_n_in(hold_line_n),
        .dly_in(dly), .phlda_out(phlda));
    initial begin
        mclk_in = 1'b0;
        forever #25 mclk_in = ~mclk_in;
    end
    task print_verdict;
        if (errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // avalon cycle: held until waitrequest is sampled low
    task av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        req <= '{read: !wr, write: wr, address: a, writedata: d};
        do begin
            @(posedge mclk_in);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        if (n >= 50) chk(32'(waitreq), 32'h0);
        q = rdata;
        req <= '0;
        @(posedge mclk_in);
    endtask : av
    // one-cycle pulse: 0 request, 1 episode end, 2 byte done, 3 transfer done
    task pulse(input int sel);
        case (sel)
            0: req_n <= 1'b0;
            1: ep_end <= 1'b1;
            2: byte_done <= 1'b1;
            default: xfer_done <= 1'b1;
        endcase
        @(posedge mclk_in);
        {req_n, ep_end, byte_done, xfer_done} <= 4'h8;
        @(posedge mclk_in);
    endtask : pulse
    // bounded wait: 0 hold enable, 1 takeover, 2 sync pulse, 3 priority
    task wait_on(input int sel, input logic v, input int lim);
        logic cur;
        for (int n = 0; n < lim; n++) begin
            @(posedge mclk_in);
            cur = (sel == 0) ? phold_oe : (sel == 1) ? take : (sel == 2) ? psync : prio;
            if (cur === v) return;
        end
        chk(32'(sel), 32'hFF);
    endtask : wait_on
    task t_reset;
        logic [31:0] q;
        chk({28'h0, waitreq, io_en, idle, wren}, 32'hE);
        av(1'b0, OFS_STATUS, 32'h0, q);
        chk(q[7:0], 32'h4);
    endtask : t_reset
    task t_locked;
        logic [31:0] q;
        pulse(0);
        repeat (8) @(posedge mclk_in);
        chk(32'(phold_oe), 32'h0);
        av(1'b1, OFS_CTRL, 32'h6, q);
        av(1'b0, OFS_STATUS, 32'h0, q);
        chk(q[2:0], 32'h4);
        av(1'b0, 4'hC, 32'h0, q);
        chk(q, 32'h0);
    endtask : t_locked
    task t_start;
        logic [31:0] q;
        av(1'b1, OFS_CTRL, 32'h7, q);
        av(1'b0, OFS_STATUS, 32'h0, q);
        chk(q[2:0], 32'h3);
        chk({wren, idle}, 32'h2);
    endtask : t_start
    task t_episode(input logic [2:0] d);
        logic [31:0] q;
        dly <= d;
        pulse(0);
        wait_on(0, 1'b1, 10);
        chk({hold_f, phold_d, prio}, 32'h4);
        wait_on(1, 1'b1, 20);
        chk({rel, psync_oe, io_en}, 32'h6);
        wait_on(2, 1'b1, 5);
        @(posedge mclk_in);
        chk(32'(psync), 32'h0);
        repeat (3) @(posedge mclk_in);
        chk(32'(psync), 32'h0);
        pulse(2);
        wait_on(2, 1'b1, 4);
        pulse(1);
        wait_on(0, 1'b0, 6);
        wait_on(1, 1'b0, 6);
        wait_on(3, 1'b1, 10);
        chk({io_en, idle}, 32'h2);
        av(1'b0, OFS_EPCOUNT, 32'h0, q);
        chk(q[7:0], 32'h2);
    endtask : t_episode
    task t_other;
        other_n <= 1'b0;
        @(posedge mclk_in);
        pulse(0);
        repeat (8) @(posedge mclk_in);
        chk({phold_oe, prio}, 32'h0);
        other_n <= 1'b1;
        wait_on(0, 1'b1, 10);
        wait_on(2, 1'b1, 20);
        pulse(1);
        wait_on(0, 1'b0, 6);
    endtask : t_other
    task t_done;
        logic [31:0] q;
        pulse(3);
        @(posedge mclk_in);
        chk({wren, idle}, 32'h1);
        av(1'b1, OFS_CTRL, 32'h7, q);
        nrst_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        nrst_in <= 1'b1;
        @(posedge mclk_in);
        chk({wren, idle}, 32'h1);
        av(1'b0, OFS_STATUS, 32'h0, q);
        chk(q[0], 32'h0);
    endtask : t_done
    initial begin
        nrst_in = 1'b0;
        {req_n, ep_end, byte_done, xfer_done, other_n} = 5'h11;
        dly = 3'h1;
        req = '0;
        repeat (5) @(posedge mclk_in);
        nrst_in <= 1'b1;
        @(posedge mclk_in);
        t_reset();
        t_locked();
        t_start();
        t_episode(3'h1);
        t_episode(3'h5);
        t_other();
        t_done();
        print_verdict();
    end
    // whole run is under two hundred cycles; this limit means a hang
    initial begin
        repeat (5000) @(posedge mclk_in);
        errors++;
        print_verdict();
    end
endmodule : test_dma_bus_acquisition
`default_nettype wire
